// ### pkg/emc_pkg.sv
// Purpose: Shared constants and types of the external static memory controller
// Assumes: 32-bit APB register bus, one external bank
// Notes:   Offsets are byte addresses

// ==========================================================
// Register map and fields
package emc_pkg;

  localparam logic [11:0] OFS_CFG  = 12'h000;
  localparam logic [11:0] OFS_TIM  = 12'h004;
  localparam logic [11:0] OFS_WTIM = 12'h008;
  localparam logic [11:0] OFS_STAT = 12'h00C;

  localparam int CFG_EN   = 0;
  localparam int CFG_W16  = 1;
  localparam int CFG_TYPE = 2;
  localparam int CFG_MUX  = 4;
  localparam int CFG_SYNC = 5;
  localparam int CFG_EXT  = 6;
  localparam int CFG_DIV  = 8;

  localparam int TIM_SET  = 0;
  localparam int TIM_DSET = 4;
  localparam int TIM_HLD  = 12;
  localparam int TIM_LAT  = 16;

  localparam logic [11:0] CFG_RST  = 12'h200;
  localparam logic [19:0] TIM_RST  = 20'h1_2021;
  localparam logic [15:0] WTIM_RST = 16'h2021;

  // ========================================================
  // Memory types, sizes, bank
  localparam logic [1:0] TYPE_SRAM  = 2'h0;
  localparam logic [1:0] TYPE_PSRAM = 2'h1;
  localparam logic [1:0] TYPE_ROM   = 2'h2;
  localparam logic [1:0] TYPE_NOR   = 2'h3;

  localparam logic [1:0] SIZE_B = 2'h0;
  localparam logic [1:0] SIZE_H = 2'h1;
  localparam logic [1:0] SIZE_W = 2'h2;

  localparam logic [5:0] BANK_SEL = 6'h01;
  localparam logic [7:0] CNT_MAX  = 8'hFF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_HOLD = 3'b010,
    ST_DATA = 3'b011,
    ST_TURN = 3'b100,
    ST_RESP = 3'b101
  } emc_state_t;

  // Zero in a timing field acts as one cycle
  function automatic logic emc_done(input logic [7:0] c, input logic [7:0] n);
    return c >= ((n == 8'h00) ? 8'h01 : n);
  endfunction

endpackage

// ### logic/emc_sync2.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs stable for at least two clocks when used as data
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps

// ==========================================================
// Synchroniser
module emc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= '1;
      q  <= '1;
    end
    else
    begin
      s1 <= d;
      q  <= s1;
    end
  end

endmodule

// ### logic/emc_ctrl.sv
// Purpose: External static memory controller, one bank
// Assumes: Request data low aligned; cfg static while busy
// Notes:   Read data sampled through a two-flop stage
//
// Summary of operation
// - Translate each bank request into SRAM, PSRAM, ROM or NOR accesses.
// - External data bus is 8 or 16 bits by configuration.
// - Equal request and bus width gives one memory access.
// - Wider requests split into back to back memory accesses.
// - Narrow access uses byte lanes; no byte select blocks writes only.
// - Active-low write enable and byte lanes, upper lane for high byte.
// - Decode one 64 megabyte external bank.
// - 8-bit memory gets byte address bits 25..0 unchanged.
// - 16-bit memory gets byte address bits 25..1 on lines 24..0.
// - Async mode outputs change only on rising pclk edges.
// - Sync mode output data change only on memory clock falling edges.
// - Memory clock only in sync mode; strobes always, wait is input.
// - Muxed NOR/PSRAM put address on data lines while address valid.
// - Optional separate write timing set, else one shared set.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module emc_ctrl
  import emc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic      [31:0] prdata,
  output logic             pslverr,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_write,
  input  wire logic [31:0] req_addr,
  input  wire logic [1:0]  req_size,
  input  wire logic [31:0] req_wdata,
  output logic             rsp_valid,
  output logic      [31:0] rsp_rdata,
  output logic             rsp_err,
  output logic      [25:0] ext_addr,
  output logic      [15:0] ext_addr_data_o,
  output logic             ext_addr_data_oe_n,
  input  wire logic [15:0] ext_addr_data_i,
  output logic             chip_select_n,
  output logic             output_enable_n,
  output logic             write_enable_n,
  output logic             address_valid_n,
  output logic      [1:0]  byte_lane_n,
  output logic             mem_clock_out,
  input  wire logic        wait_in_n
);

  // ========================================================
  // Configuration registers over APB
  logic [11:0] cfg;
  logic [19:0] tim;
  logic [15:0] wtim;

  emc_state_t state;
  emc_state_t next_state;
  emc_state_t nst;

  logic [7:0]  cnt;
  logic [25:0] addr_q;
  logic [1:0]  size_q;
  logic        wr_q;
  logic [31:0] wdata_q;
  logic [2:0]  left;
  logic [1:0]  beat;
  logic [31:0] acc;
  logic [3:0]  div_cnt;
  logic        wait_q;
  logic [15:0] din_q;

  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pready & pwrite;
  wire sel_cfg   = paddr == OFS_CFG;
  wire sel_tim   = paddr == OFS_TIM;
  wire sel_wtim  = paddr == OFS_WTIM;
  wire sel_stat  = paddr == OFS_STAT;
  wire mapped    = sel_cfg | sel_tim | sel_wtim | sel_stat;
  wire busy      = state != ST_IDLE;
  wire wait_s    = ~wait_q;

  wire [31:0] stat_word = {29'h0, rsp_err, wait_s, busy};
  wire [31:0] rd_mux =
    sel_cfg  ? {20'h0, cfg}  :
    sel_tim  ? {12'h0, tim}  :
    sel_wtim ? {16'h0, wtim} :
    sel_stat ? stat_word     : 32'h0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= apb_setup;
      prdata  <= (apb_setup & ~pwrite) ? rd_mux : 32'h0;
      pslverr <= apb_setup & ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg  <= CFG_RST;
      tim  <= TIM_RST;
      wtim <= WTIM_RST;
    end
    else if (apb_wr)
    begin
      if (sel_cfg)
        cfg <= pwdata[11:0];
      if (sel_tim)
        tim <= pwdata[19:0];
      if (sel_wtim)
        wtim <= pwdata[15:0];
    end
  end

  // ========================================================
  // Configuration decode
  wire       w16      = cfg[CFG_W16];
  wire       cfg_sync = cfg[CFG_SYNC];
  wire [1:0] mtype    = cfg[CFG_TYPE +: 2];
  wire [3:0] half     = cfg[CFG_DIV +: 4];
  wire       muxed    = cfg[CFG_MUX]
                      & (mtype == TYPE_PSRAM | mtype == TYPE_NOR);

  // Separate write set only when enabled
  wire       wt   = cfg[CFG_EXT] & wr_q;
  wire [7:0] aset = {4'h0, wt ? wtim[TIM_SET +: 4] : tim[TIM_SET +: 4]};
  wire [7:0] dset = wt ? wtim[TIM_DSET +: 8] : tim[TIM_DSET +: 8];
  wire [7:0] ahld = {4'h0, wt ? wtim[TIM_HLD +: 4] : tim[TIM_HLD +: 4]};
  wire [7:0] blat = {4'h0, tim[TIM_LAT +: 4]};

  // ========================================================
  // Memory clock divider
  wire [3:0] half_m1   = (half == 4'h0) ? 4'h0 : half - 4'h1;
  wire       div_end   = div_cnt >= half_m1;
  wire       fall_tick = cfg_sync & mem_clock_out & div_end;
  // Async mode steps on every pclk edge
  wire       tick      = ~cfg_sync | fall_tick;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_cnt       <= 4'h0;
      mem_clock_out <= 1'b0;
    end
    else if (!cfg_sync)
    begin
      div_cnt       <= 4'h0;
      mem_clock_out <= 1'b0;
    end
    else if (div_end)
    begin
      div_cnt       <= 4'h0;
      mem_clock_out <= ~mem_clock_out;
    end
    else
      div_cnt <= div_cnt + 4'h1;
  end

  // ========================================================
  // Pin input synchronisers
  emc_sync2 #(.W(1)) u_wait_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (wait_in_n),
    .q     (wait_q)
  );

  emc_sync2 #(.W(16)) u_data_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (ext_addr_data_i),
    .q     (din_q)
  );

  // ========================================================
  // Request decode
  wire in_bank = req_addr[31:26] == BANK_SEL;
  // No byte select on NOR: narrow write refused, read allowed
  wire blocked = req_write & w16 & (req_size == SIZE_B)
               & (mtype == TYPE_NOR);
  wire bad     = ~cfg[CFG_EN] | ~in_bank | blocked;
  wire accept  = req_valid & req_ready;

  // Beats per request
  wire [2:0] nbeats =
    (req_size == SIZE_B) ? 3'h1 :
    (req_size == SIZE_H) ? (w16 ? 3'h1 : 3'h2) :
                           (w16 ? 3'h2 : 3'h4);

  // ========================================================
  // Beat address and data
  wire [25:0] beat_ofs = w16 ? {23'h0, beat, 1'b0} : {24'h0, beat};
  wire [25:0] baddr    = addr_q + beat_ofs;
  wire [24:0] baddr_hw = baddr[25:1];
  // Half-word address for 16-bit parts
  wire [25:0] eaddr    = w16 ? {1'b0, baddr_hw} : baddr;

  wire [7:0]  wbyte = wdata_q[{beat, 3'b000} +: 8];
  wire [15:0] whalf = wdata_q[{beat[0], 4'h0} +: 16];
  wire [15:0] wbus  = !w16 ? {8'h00, wbyte} :
                      (size_q == SIZE_B) ? {wbyte, wbyte} : whalf;
  // Upper lane qualifies the high byte
  wire [1:0]  lanes = !w16 ? 2'h2 :
                      (size_q == SIZE_B) ? {~addr_q[0], addr_q[0]} : 2'h0;

  // Wait stretches the data phase
  wire data_done = emc_done(cnt, dset) & ~wait_s;

  // ========================================================
  // Access sequencer
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (accept)
          next_state = bad ? ST_RESP : ST_ADDR;
      ST_ADDR:
        if (emc_done(cnt, aset))
          next_state = muxed ? ST_HOLD : ST_DATA;
      ST_HOLD:
        if (emc_done(cnt, ahld))
          next_state = ST_DATA;
      ST_DATA:
        if (data_done)
          next_state = ST_TURN;
      ST_TURN:
        if (emc_done(cnt, blat))
          next_state = (left == 3'h0) ? ST_RESP : ST_ADDR;
      ST_RESP:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  // Idle and response never wait for a memory clock edge
  wire adv = tick | (state == ST_IDLE) | (state == ST_RESP);
  assign nst = adv ? next_state : state;
  wire data_exit = (state == ST_DATA) & (nst == ST_TURN);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= ST_IDLE;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_err   <= 1'b0;
      rsp_rdata <= 32'h0;
    end
    else
    begin
      state     <= nst;
      req_ready <= nst == ST_IDLE;
      rsp_valid <= nst == ST_RESP;
      if (nst == ST_RESP)
      begin
        rsp_err   <= (state == ST_IDLE) & bad;
        rsp_rdata <= (state == ST_IDLE) ? 32'h0 : acc;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 8'h01;
    else if (nst != state)
      cnt <= 8'h01;
    else if (adv && cnt != CNT_MAX)
      cnt <= cnt + 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_q  <= 26'h0;
      size_q  <= SIZE_B;
      wr_q    <= 1'b0;
      wdata_q <= 32'h0;
      left    <= 3'h0;
      beat    <= 2'h0;
    end
    else if (accept)
    begin
      addr_q  <= req_addr[25:0];
      size_q  <= req_size;
      wr_q    <= req_write;
      wdata_q <= req_wdata;
      left    <= nbeats;
      beat    <= 2'h0;
    end
    else if (data_exit)
    begin
      left <= left - 3'h1;
      beat <= beat + 2'h1;
    end
  end

  // Read beats assemble low aligned
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc <= 32'h0;
    else if (accept)
      acc <= 32'h0;
    else if (data_exit && !wr_q)
    begin
      if (!w16)
        acc[{beat, 3'b000} +: 8] <= din_q[7:0];
      else if (size_q == SIZE_B)
        acc[7:0] <= addr_q[0] ? din_q[15:8] : din_q[7:0];
      else
        acc[{beat[0], 4'h0} +: 16] <= din_q;
    end
  end

  // ========================================================
  // Memory pins, stepped only on ticks
  wire in_acc  = (state == ST_ADDR) | (state == ST_HOLD)
               | (state == ST_DATA) | (state == ST_TURN);
  wire in_aph  = (state == ST_ADDR) | (state == ST_HOLD);
  wire in_dat  = state == ST_DATA;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chip_select_n      <= 1'b1;
      address_valid_n    <= 1'b1;
      output_enable_n    <= 1'b1;
      write_enable_n     <= 1'b1;
      byte_lane_n        <= 2'h3;
      ext_addr           <= 26'h0;
      ext_addr_data_o    <= 16'h0;
      ext_addr_data_oe_n <= 1'b1;
    end
    else if (tick)
    begin
      chip_select_n      <= ~in_acc;
      address_valid_n    <= state != ST_ADDR;
      output_enable_n    <= ~(in_dat & ~wr_q);
      write_enable_n     <= ~(in_dat & wr_q);
      byte_lane_n        <= in_acc ? lanes : 2'h3;
      ext_addr           <= eaddr;
      ext_addr_data_o    <= in_aph ? eaddr[15:0] : wbus;
      ext_addr_data_oe_n <= ~((in_aph & muxed) | (in_dat & wr_q));
    end
  end

  // ========================================================
  // Checks
  property p_addr8;
    @(posedge pclk) disable iff (!presetn)
    (tick && state == ST_ADDR && !w16) |=> ext_addr == $past(baddr);
  endproperty
  a_addr8: assert property (p_addr8)
    else $error("8-bit address not passed unchanged");

  property p_addr16;
    @(posedge pclk) disable iff (!presetn)
    (tick && state == ST_ADDR && w16)
      |=> ext_addr[24:0] == $past(baddr_hw) && !ext_addr[25];
  endproperty
  a_addr16: assert property (p_addr16)
    else $error("16-bit address not shifted");

  property p_single;
    @(posedge pclk) disable iff (!presetn)
    (accept && !bad && req_size == SIZE_H && w16) |=> left == 3'h1;
  endproperty
  a_single: assert property (p_single)
    else $error("Matched width not one access");

  property p_split;
    @(posedge pclk) disable iff (!presetn)
    (accept && !bad && req_size == SIZE_W && !w16) |=> left == 3'h4;
  endproperty
  a_split: assert property (p_split)
    else $error("Word on 8-bit bus not four accesses");

  property p_block;
    @(posedge pclk) disable iff (!presetn)
    (accept && blocked) |=> rsp_valid && rsp_err && chip_select_n;
  endproperty
  a_block: assert property (p_block)
    else $error("Narrow write without byte select not refused");

  property p_lane;
    @(posedge pclk) disable iff (!presetn)
    (!write_enable_n && w16 && size_q == SIZE_B)
      |-> byte_lane_n == {~addr_q[0], addr_q[0]};
  endproperty
  a_lane: assert property (p_lane)
    else $error("Wrong byte lane for narrow write");

  property p_bank;
    @(posedge pclk) disable iff (!presetn)
    (accept && !in_bank) |=> rsp_valid && rsp_err;
  endproperty
  a_bank: assert property (p_bank)
    else $error("Access outside bank not refused");

  property p_syncdata;
    @(posedge pclk) disable iff (!presetn)
    (cfg_sync && $past(cfg_sync) && !$stable(ext_addr_data_o))
      |-> $past(fall_tick);
  endproperty
  a_syncdata: assert property (p_syncdata)
    else $error("Sync data changed off memory clock fall");

  property p_noclk;
    @(posedge pclk) disable iff (!presetn)
    !cfg_sync |=> !mem_clock_out;
  endproperty
  a_noclk: assert property (p_noclk)
    else $error("Memory clock running in async mode");

  property p_mux;
    @(posedge pclk) disable iff (!presetn)
    (!address_valid_n && muxed)
      |-> !ext_addr_data_oe_n && ext_addr_data_o == ext_addr[15:0];
  endproperty
  a_mux: assert property (p_mux)
    else $error("Muxed address missing on data lines");

  property p_wait;
    @(posedge pclk) disable iff (!presetn)
    (tick && state == ST_DATA && wait_s) |=> state == ST_DATA;
  endproperty
  a_wait: assert property (p_wait)
    else $error("Data phase left while wait active");

endmodule

// ### tb/emc_mem_model.sv
// Purpose: Behavioural external static memory on the controller pins
// Assumes: Width and mux mode given by the bench from its own config copy
// Notes:   Combinational read path; released bus shows inverse of last value
`timescale 1ns/1ps

// ==========================================================
// Memory model
module emc_mem_model
  import emc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        w16,
  input  wire logic        mux,
  input  wire logic [7:0]  stall,
  input  wire logic [25:0] ext_addr,
  input  wire logic [15:0] ext_addr_data_o,
  input  wire logic        ext_addr_data_oe_n,
  output logic      [15:0] ext_addr_data_i,
  input  wire logic        chip_select_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic        address_valid_n,
  input  wire logic [1:0]  byte_lane_n,
  output logic             wait_in_n
);
  logic [7:0]  mem [0:255];
  logic [15:0] lat_addr = 16'h0000;
  logic [15:0] last     = 16'h0000;
  logic [7:0]  wcnt     = 8'h00;
  logic        strobe_d = 1'b0;
  wire  [15:0] cur_addr = mux ? lat_addr : ext_addr[15:0];
  wire  [7:0]  base     = w16 ? {cur_addr[6:0], 1'b0} : cur_addr[7:0];
  wire         strobe   = !chip_select_n && !(output_enable_n && write_enable_n);

  // Drive only while selected and read strobe low
  assign ext_addr_data_i = (!chip_select_n && !output_enable_n) ?
                           {mem[base + 8'h01], mem[base]} : ~last;
  // Wait line released unless a stall is being counted out
  assign wait_in_n = (wcnt == 8'h00);

  always @(posedge pclk)
  begin
    if (!chip_select_n && !address_valid_n)
      lat_addr <= ext_addr_data_o;
    if (!chip_select_n && !output_enable_n)
      last <= ext_addr_data_i;
    if (!chip_select_n && !write_enable_n && !w16)
      mem[base] <= ext_addr_data_o[7:0];
    if (!chip_select_n && !write_enable_n && w16 && !byte_lane_n[0])
      mem[base] <= ext_addr_data_o[7:0];
    if (!chip_select_n && !write_enable_n && w16 && !byte_lane_n[1])
      mem[base + 8'h01] <= ext_addr_data_o[15:8];
    strobe_d <= strobe;
    if (strobe && !strobe_d)
      wcnt <= stall;
    else if (wcnt != 8'h00)
      wcnt <= wcnt - 8'h01;
  end
endmodule

// ### tb/ext_static_memory_ctrl_test.sv
// Purpose: Self-checking bench of the external memory controller
// Assumes: Config static during each memory request
// Notes:   Table rows first; wait, clock and reset cases by hand after
`timescale 1ns/1ps

module ext_static_memory_ctrl_test
  import emc_pkg::*;
;
  typedef struct packed {
    logic [11:0] cfg;
    logic        wr;
    logic [31:0] addr;
    logic [1:0]  size;
    logic [31:0] data;
    logic        err;
  } emc_row_t;

  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000, cfg = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, req_addr = 32'h0000_0000, req_wdata = 32'h0000_0000;
  logic        req_valid = 1'b0, req_write = 1'b0;
  logic [1:0]  req_size = 2'h0;
  logic [7:0]  stall = 8'h00;
  logic        pready, pslverr, req_ready, rsp_valid, rsp_err, ext_addr_data_oe_n;
  logic        chip_select_n, output_enable_n, write_enable_n, address_valid_n, mem_clock_out;
  logic [31:0] prdata, rsp_rdata, rd;
  logic [25:0] ext_addr, seen_addr;
  logic [15:0] ext_addr_data_o;
  logic [1:0]  byte_lane_n;
  wire  [15:0] ext_addr_data_i;
  wire         wait_in_n;
  logic        rerr;
  int          miscompares = 0, compares = 0, cycles = 0, lat = 0, base_lat = 0, clk_edges = 0;

  // ==========================================================
  // Cases: cfg, write, address, size, data, refused
  emc_row_t rows [13] = '{
    '{12'h201, 1'b1, 32'h0400_0010, SIZE_W, 32'h4433_2211, 1'b0},
    '{12'h201, 1'b0, 32'h0400_0012, SIZE_B, 32'h0000_0033, 1'b0},
    '{12'h203, 1'b0, 32'h0400_0010, SIZE_W, 32'h4433_2211, 1'b0},
    '{12'h203, 1'b1, 32'h0400_0013, SIZE_B, 32'h0000_0055, 1'b0},
    '{12'h203, 1'b0, 32'h0400_0012, SIZE_H, 32'h0000_5533, 1'b0},
    '{12'h21F, 1'b1, 32'h0400_0010, SIZE_B, 32'h0000_0099, 1'b1},
    '{12'h21F, 1'b0, 32'h0400_0011, SIZE_B, 32'h0000_0022, 1'b0},
    '{12'h217, 1'b1, 32'h0400_0020, SIZE_H, 32'h0000_BEEF, 1'b0},
    '{12'h227, 1'b0, 32'h0400_0020, SIZE_H, 32'h0000_BEEF, 1'b0},
    '{12'h243, 1'b1, 32'h0400_0030, SIZE_W, 32'hCAFE_F00D, 1'b0},
    '{12'h20B, 1'b0, 32'h0400_0030, SIZE_W, 32'hCAFE_F00D, 1'b0},
    '{12'h200, 1'b0, 32'h0400_0010, SIZE_W, 32'h0000_0000, 1'b1},
    '{12'h203, 1'b0, 32'h0800_0010, SIZE_W, 32'h0000_0000, 1'b1}
  };

  emc_ctrl emc_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_size(req_size), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_err(rsp_err), .ext_addr(ext_addr),
    .ext_addr_data_o(ext_addr_data_o), .ext_addr_data_oe_n(ext_addr_data_oe_n),
    .ext_addr_data_i(ext_addr_data_i), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .address_valid_n(address_valid_n), .byte_lane_n(byte_lane_n),
    .mem_clock_out(mem_clock_out), .wait_in_n(wait_in_n)
  );

  emc_mem_model emc_mem_model_inst (
    .pclk(pclk), .w16(cfg[CFG_W16]), .mux(cfg[CFG_MUX]), .stall(stall),
    .ext_addr(ext_addr), .ext_addr_data_o(ext_addr_data_o),
    .ext_addr_data_oe_n(ext_addr_data_oe_n), .ext_addr_data_i(ext_addr_data_i),
    .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
    .write_enable_n(write_enable_n), .address_valid_n(address_valid_n),
    .byte_lane_n(byte_lane_n), .wait_in_n(wait_in_n)
  );

  always #5 pclk = ~pclk;
  always @(posedge mem_clock_out) clk_edges++;
  // Address as it stands under a strobe; it moves on during turnaround
  always @(posedge pclk)
    if (output_enable_n === 1'b0 || write_enable_n === 1'b0)
      seen_addr <= ext_addr;
  // Controller must not drive the data lines while the memory does
  always @(posedge pclk)
    if (presetn === 1'b1 && output_enable_n === 1'b0)
      chk({31'h0000_0000, ext_addr_data_oe_n}, 32'h0000_0001);

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Entered just after a rising edge; answer taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      miscompares++;
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic mem_op(input emc_row_t r);
    int n;
    n = 0;
    req_valid <= 1'b1;
    req_write <= r.wr;
    req_addr <= r.addr;
    req_size <= r.size;
    req_wdata <= r.data;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (req_ready !== 1'b1 && n < 50);
    if (req_ready !== 1'b1)
      miscompares++;
    req_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(posedge pclk);
      lat++;
    end
    while (rsp_valid !== 1'b1 && lat < 2000);
    if (rsp_valid !== 1'b1)
      miscompares++;
    rd = rsp_rdata;
    rerr = rsp_err;
  endtask

  task automatic set_cfg(input logic [11:0] c);
    cfg = c;
    apb(1'b1, OFS_CFG, {20'h0_0000, c});
  endtask

  // ==========================================================
  // Timeout
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      conclude();
    end
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Long data phase: two-flop read sampling and wait sync must both fit in it
    apb(1'b1, OFS_TIM, 32'h0001_2061);
    apb(1'b1, OFS_WTIM, 32'h0000_2051);
    apb(1'b0, OFS_TIM, 32'h0000_0000);
    chk(rd, 32'h0001_2061);
    apb(1'b0, OFS_WTIM, 32'h0000_0000);
    chk(rd, 32'h0000_2051);
    foreach (rows[i])
    begin
      set_cfg(rows[i].cfg);
      mem_op(rows[i]);
      chk({31'h0000_0000, rerr}, {31'h0000_0000, rows[i].err});
      if (!rows[i].wr && !rows[i].err)
        chk(rd, rows[i].data);
    end
    // Address shift per bus width, then a stalled access
    set_cfg(12'h201);
    mem_op('{12'h201, 1'b0, 32'h0400_0012, SIZE_B, 32'h0000_0000, 1'b0});
    chk({6'h00, seen_addr}, 32'h0000_0012);
    set_cfg(12'h203);
    mem_op('{12'h203, 1'b0, 32'h0400_0012, SIZE_H, 32'h0000_0000, 1'b0});
    chk({6'h00, seen_addr}, 32'h0000_0009);
    base_lat = lat;
    stall = 8'h06;
    mem_op('{12'h203, 1'b0, 32'h0400_0012, SIZE_H, 32'h0000_0000, 1'b0});
    stall = 8'h00;
    chk(rd, 32'h0000_5533);
    chk({31'h0000_0000, lat >= base_lat + 2}, 32'h0000_0001);
    // Memory clock idle in async mode, running in sync mode
    clk_edges = 0;
    repeat (40) @(posedge pclk);
    chk(32'(clk_edges), 32'h0000_0000);
    set_cfg(12'h227);
    clk_edges = 0;
    repeat (40) @(posedge pclk);
    chk({31'h0000_0000, clk_edges > 0}, 32'h0000_0001);
    // Reset in mid-run, then reset values and an unmapped offset
    presetn <= 1'b0;
    @(posedge pclk);
    chk({29'h0000_0000, req_ready, byte_lane_n}, 32'h0000_0003);
    chk({30'h0000_0000, chip_select_n, write_enable_n}, 32'h0000_0003);
    repeat (7) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_CFG, 32'h0000_0000);
    chk(rd, 32'h0000_0200);
    apb(1'b0, OFS_TIM, 32'h0000_0000);
    chk(rd, 32'h0001_2021);
    apb(1'b0, OFS_WTIM, 32'h0000_0000);
    chk(rd, 32'h0000_2021);
    apb(1'b0, 12'h010, 32'h0000_0000);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
    conclude();
  end
endmodule
